/* pctc_core_model.sv */
// Purpose: Behavioural core that answers the test port
// Assumes: Link condition is set by the bench
// Notes:   Scrambling and low power choices have no visible effect here
`timescale 1ns/1ps

module pctc_core_model (
  // Clock
  input wire          sys_clk,
  // Test port
  input wire [31:0]   test_in,
  output reg          testin_zero,
  output wire [3:0]   lane_act,
  // Link condition from the bench
  input wire          link_up,
  input wire [1:0]    width_sel,
  input wire [1:0]    speed,
  input wire [7:0]    hdr_cr,
  input wire [11:0]   dat_cr,
  input wire          err_rcv,
  // Board status
  output wire [255:0] devkit_status
);
  reg [4:0] ltssm_reg;

  // Fast init indicator follows the simulation bit
  always @(posedge sys_clk)
    testin_zero <= test_in[0];

  // One-hot lane count
  assign lane_act = 4'h1 << width_sel;

  // Compliance held off by bit 5, forced by bit 6 when not held
  always @(posedge sys_clk)
    ltssm_reg <= link_up ? 5'h0f : ((!test_in[5] && test_in[6]) ? 5'h03 : 5'h02);

  // Status bus packing; the error pulse doubles as a 1 us tick
  assign devkit_status = {208'h0, dat_cr, hdr_cr, ltssm_reg, lane_act, 6'h0, err_rcv, 2'h0,
                          link_up, 6'h0, err_rcv, speed};
endmodule // pctc_core_model

/* pctc_ctrl.v */
// Purpose: Host side controller that drives the core test control bus
//          and the board control conduit, and gathers board status
// Assumes: Software reaches the controller over AXI4-Lite, 32-bit data
// Notes:   Status pins pass a two-flop bank before any logic reads them
//
// What this block does
// RQ1: Test control bus leaves reset at its normal value and returns there.
// RQ2: Core shortens init counters when bit 0 is high; software may set it.
// RQ3: Reserved bit 1 is forced low whatever software writes.
// RQ4: Scrambling disable bit 2 is driven during init when software asks.
// RQ5: Scrambling disable is honoured only in simulation builds.
// RQ6: Reserved bits 4:3 are forced to binary 01.
// RQ7: Compliance hold bit 5 is software controlled and may toggle live.
// RQ8: Compliance hold bit 5 leaves reset cleared.
// RQ9: Forced compliance on polling timeout is bit 6, software controlled.
// RQ10: Low power negotiation disable bit 7 is set by default.
// RQ11: Bit 8 is forced high.
// RQ12: Reserved bits 31:9 are forced low.
// RQ13: Accelerated init indicator is synchronised and shown in status.
// RQ14: One-hot active lane code is synchronised and shown in status.
// RQ15: Speed, error, parity and link up fields are decoded from bits 9:0.
// RQ16: Link exit, ticks, interrupts, lanes and training state decoded.
// RQ17: Completion credits, overflow and reset status decoded; rest ignored.
// RQ18: Board control carries the test word in 31:0 and zeros above.
// RQ19: Board control stands in for switches, carrying the live test word.
// RQ20: Conduit logic exists only when the conduit parameter is set.
// RQ21: While link is up only the compliance bit may change.
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pctc_defs.vh"

module pctc_ctrl #(
  parameter HAS_CONDUIT = 1,
  parameter SIM_BUILD   = 0
) (
  // Clock and reset
  input  wire                    sys_clk,
  input  wire                    rst,
  // AXI4-Lite write address
  input  wire [`PCTC_ADDR_W-1:0] s_axi_awaddr,
  input  wire                    s_axi_awvalid,
  output wire                    s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output wire                    s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]              s_axi_bresp,
  output wire                    s_axi_bvalid,
  input  wire                    s_axi_bready,
  // AXI4-Lite read address
  input  wire [`PCTC_ADDR_W-1:0] s_axi_araddr,
  input  wire                    s_axi_arvalid,
  output wire                    s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0]             s_axi_rdata,
  output wire [1:0]              s_axi_rresp,
  output wire                    s_axi_rvalid,
  input  wire                    s_axi_rready,
  // Core test port
  output wire [31:0]             test_in,
  input  wire                    testin_zero,
  input  wire [3:0]              lane_act,
  // Board conduit
  output wire [255:0]            devkit_ctrl,
  input  wire [255:0]            devkit_status
);

  // ******************************************************************
  // Input synchronisers
  // ******************************************************************
  localparam SYNC_W = `PCTC_ST_USED_W + 5;

  wire [SYNC_W-1:0] raw_pins;
  wire [SYNC_W-1:0] sync_pins;
  wire [`PCTC_ST_USED_W-1:0] board_used;
  wire [`PCTC_ST_USED_W-1:0] st;
  wire              accel_seen;
  wire [3:0]        lanes_seen;

  // Only the documented status bits are carried; 255:50 are reserved
  assign board_used = devkit_status[`PCTC_ST_USED_W-1:0];
  assign raw_pins   = {board_used, lane_act, testin_zero};

  pctc_sync2 #(
    .WIDTH    (SYNC_W)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (raw_pins),
    .sync_out (sync_pins)
  );

  // Without the conduit the status bus is absent and reads as zero
  assign accel_seen = sync_pins[0];                                     // RQ13
  assign lanes_seen = sync_pins[4:1];                                   // RQ14
  assign st = (HAS_CONDUIT != 0) ? sync_pins[SYNC_W-1:5]                 // RQ20
                                 : {`PCTC_ST_USED_W{1'b0}};

  // ******************************************************************
  // Board status decode
  // ******************************************************************
  wire [1:0]  link_speed;
  wire        link_up;
  wire [3:0]  int_status;
  wire [3:0]  board_lanes;
  wire [4:0]  train_state;
  wire [7:0]  completion_header_credits;
  wire [11:0] completion_data_credits;
  wire        reset_status;
  wire        tick_1_us;
  wire        tick_128_ns;
  wire [`PCTC_EVT_W-2:0] evt_src;

  assign link_speed   = st[`PCTC_ST_SPEED_LO+1:`PCTC_ST_SPEED_LO];      // RQ15
  assign link_up      = st[`PCTC_ST_LINK_UP];                           // RQ15
  assign tick_128_ns  = st[`PCTC_ST_TICK_128NS];                        // RQ16
  assign tick_1_us    = st[`PCTC_ST_TICK_1US];                          // RQ16
  assign int_status   = st[`PCTC_ST_INT_LO+3:`PCTC_ST_INT_LO];          // RQ16
  assign board_lanes  = st[`PCTC_ST_LANE_LO+3:`PCTC_ST_LANE_LO];        // RQ16
  assign train_state  = st[`PCTC_ST_LTSSM_LO+4:`PCTC_ST_LTSSM_LO];      // RQ16
  assign completion_header_credits = st[`PCTC_ST_HDR_CR_LO+7:`PCTC_ST_HDR_CR_LO]; // RQ17
  assign completion_data_credits   = st[`PCTC_ST_DAT_CR_LO+11:`PCTC_ST_DAT_CR_LO]; // RQ17
  assign reset_status = st[`PCTC_ST_RESET_STAT];                        // RQ17

  // Error and exit flags that latch into the event register
  assign evt_src = {st[`PCTC_ST_SLEEP_EXIT],                            // RQ16
                    st[`PCTC_ST_HOTRST_EXIT],
                    st[`PCTC_ST_LINK_EXIT],
                    st[`PCTC_ST_CPL_OVF],                               // RQ17
                    st[`PCTC_ST_CFG_PAR],                               // RQ15
                    |st[`PCTC_ST_TX_PAR_HI:`PCTC_ST_TX_PAR_LO],
                    st[`PCTC_ST_RX_PAR],
                    st[`PCTC_ST_DATA_ERR],
                    st[`PCTC_ST_COR_RPL],
                    st[`PCTC_ST_COR_RCV]};

  // ******************************************************************
  // AXI4-Lite write path
  // ******************************************************************
  reg                    aw_full_reg;
  reg [`PCTC_ADDR_W-1:0] aw_addr_reg;
  reg                    w_full_reg;
  reg [31:0]             w_data_reg;
  reg [3:0]              w_strb_reg;
  reg                    bvalid_reg;
  reg [1:0]              bresp_reg;
  wire                   wr_fire;
  wire [31:0]            wr_mask;
  wire                   wr_mapped;

  // Address and data are held separately, so either may arrive first
  assign s_axi_awready = ~aw_full_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_full_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign wr_fire       = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr_mask       = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                          {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign wr_mapped     = (aw_addr_reg == `PCTC_REG_CTRL) |
                         (aw_addr_reg == `PCTC_REG_CMD)  |
                         (aw_addr_reg == `PCTC_REG_EVT);

  // Capture each channel, perform the write once both are in hand
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= {`PCTC_ADDR_W{1'b0}};
      w_full_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `PCTC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[`PCTC_ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_mapped ? `PCTC_RESP_OKAY : `PCTC_RESP_SLVERR;
      end
      else if (bvalid_reg & s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ******************************************************************
  // Software image, live test word and commands
  // ******************************************************************
  reg  [31:0] ctrl_reg;
  reg  [31:0] ctrl_next;
  reg  [31:0] live_reg;
  reg  [31:0] live_next;
  reg         refused_pulse;
  wire        wr_ctrl;
  wire        wr_cmd;
  wire        cmd_apply;
  wire        cmd_toggle;
  wire [31:0] free_mask;
  wire [31:0] wanted;

  assign wr_ctrl    = wr_fire & (aw_addr_reg == `PCTC_REG_CTRL);
  assign wr_cmd     = wr_fire & (aw_addr_reg == `PCTC_REG_CMD) & w_strb_reg[0];
  assign cmd_apply  = wr_cmd & w_data_reg[`PCTC_CMD_APPLY];
  assign cmd_toggle = wr_cmd & w_data_reg[`PCTC_CMD_TOGGLE];

  // A real link partner scrambles, so descrambling is kept for simulation
  assign free_mask = (SIM_BUILD != 0) ? `PCTC_TI_FREE_MASK               // RQ5
                   : (`PCTC_TI_FREE_MASK & ~(32'h00000001 << `PCTC_TI_NO_SCRAMBLE));
  // Reserved and fixed bits are never taken from software
  assign wanted = (ctrl_reg & free_mask) | `PCTC_TI_FIXED;              // RQ3 RQ6 RQ11 RQ12

  // Byte-lane write of the software image
  always @*
  begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl)
    begin
      ctrl_next = (ctrl_reg & ~wr_mask) | (w_data_reg & wr_mask);
    end
  end

  // Live word: full apply only before link up, compliance bit anytime
  always @*
  begin
    live_next     = live_reg;
    refused_pulse = 1'b0;
    if (cmd_apply)
    begin
      if (!link_up)
      begin
        live_next = wanted;                                             // RQ2 RQ4 RQ9 RQ10
      end
      else
      begin
        live_next[`PCTC_TI_COMPL_HOLD] = wanted[`PCTC_TI_COMPL_HOLD];   // RQ21
        refused_pulse = ((live_reg ^ wanted) &
                         ~(32'h00000001 << `PCTC_TI_COMPL_HOLD)) != 32'h00000000;
      end
    end
    if (cmd_toggle)
    begin
      live_next[`PCTC_TI_COMPL_HOLD] = ~live_next[`PCTC_TI_COMPL_HOLD];  // RQ7
    end
  end

  // Both words leave reset at the normal operating value
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl_reg <= `PCTC_TI_DEFAULT;                                     // RQ1 RQ8
      live_reg <= `PCTC_TI_DEFAULT;                                     // RQ1 RQ8 RQ10
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      live_reg <= live_next;
    end
  end

  assign test_in = live_reg;
  // Board control mirrors the test word; upper lanes stay at zero
  assign devkit_ctrl = (HAS_CONDUIT != 0) ? {224'h0, live_reg}          // RQ18 RQ19 RQ20
                                          : 256'h0;

  // ******************************************************************
  // Sticky events and link uptime
  // ******************************************************************
  reg  [`PCTC_EVT_W-1:0] evt_reg;
  reg  [`PCTC_EVT_W-1:0] evt_next;
  reg  [31:0]            uptime_reg;
  reg                    tick_prev_reg;
  wire [`PCTC_EVT_W-1:0] evt_set;
  wire [`PCTC_EVT_W-1:0] evt_clr;
  wire                   tick_rise;

  assign evt_set = {refused_pulse, evt_src};
  assign evt_clr = (wr_fire & (aw_addr_reg == `PCTC_REG_EVT))
                 ? (w_data_reg[`PCTC_EVT_W-1:0] & wr_mask[`PCTC_EVT_W-1:0])
                 : {`PCTC_EVT_W{1'b0}};

  // Write one to clear; a new event in the clear cycle is kept
  always @*
  begin
    evt_next = (evt_reg & ~evt_clr) | evt_set;
  end

  assign tick_rise = tick_1_us & ~tick_prev_reg;

  // Microseconds since link up; restarts whenever the link drops
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      evt_reg       <= {`PCTC_EVT_W{1'b0}};
      uptime_reg    <= 32'h00000000;
      tick_prev_reg <= 1'b0;
    end
    else
    begin
      evt_reg       <= evt_next;
      tick_prev_reg <= tick_1_us;
      if (!link_up)
      begin
        uptime_reg <= 32'h00000000;
      end
      else if (tick_rise && (uptime_reg != 32'hffffffff))
      begin
        uptime_reg <= uptime_reg + 32'h00000001;                        // RQ16
      end
    end
  end

  // ******************************************************************
  // AXI4-Lite read path
  // ******************************************************************
  reg        rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0]  rresp_reg;
  reg [31:0] rd_word;
  reg        rd_ok;
  wire [`PCTC_ADDR_W-1:0] rd_addr;

  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign rd_addr       = {s_axi_araddr[`PCTC_ADDR_W-1:2], 2'b00};

  // Read mux; unmapped words answer zero with a slave error
  always @*
  begin
    rd_word = 32'h00000000;
    rd_ok   = 1'b1;
    case (rd_addr)
      `PCTC_REG_CTRL:
        rd_word = ctrl_reg;
      `PCTC_REG_CMD:
        rd_word = 32'h00000000;
      `PCTC_REG_STAT:
        rd_word = {9'h000, tick_128_ns, board_lanes, reset_status,       // RQ13 RQ14
                   int_status, train_state, lanes_seen, accel_seen,
                   link_up, link_speed};
      `PCTC_REG_CRED:
        rd_word = {12'h000, completion_data_credits, completion_header_credits};
      `PCTC_REG_EVT:
        rd_word = {{(32-`PCTC_EVT_W){1'b0}}, evt_reg};
      `PCTC_REG_UPTIME:
        rd_word = uptime_reg;
      `PCTC_REG_LIVE:
        rd_word = live_reg;
      default:
        rd_ok = 1'b0;
    endcase
  end

  // Read answers one cycle after the address is taken
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `PCTC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid & ~rvalid_reg)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_word;
        rresp_reg  <= rd_ok ? `PCTC_RESP_OKAY : `PCTC_RESP_SLVERR;
      end
      else if (rvalid_reg & s_axi_rready)
      begin
        rvalid_reg <= 1'b0;
      end
    end
  end

endmodule // pctc_ctrl

/* pctc_ctrl_properties.sv */
// Purpose: Port checker for the test control conduit controller
// Assumes: One clock, synchronous active high reset
// Notes:   Bound into every pctc_ctrl instance
`timescale 1ns/1ps
`include "pctc_defs.vh"

module pctc_props #(
  parameter HAS_CONDUIT = 1
) (
  // Clock and reset
  input wire         sys_clk,
  input wire         rst,
  // Bus handshakes
  input wire         s_axi_arvalid,
  input wire         s_axi_arready,
  input wire         s_axi_rvalid,
  input wire         s_axi_bvalid,
  input wire         s_axi_bready,
  input wire [1:0]   s_axi_bresp,
  // Core test port
  input wire [31:0]  test_in,
  input wire [255:0] devkit_ctrl
);
  // ******************************************************************
  // Sequences and properties
  // ******************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  sequence s_b_waiting;
    s_axi_bvalid && !s_axi_bready;
  endsequence

  // Reset release must leave the normal word; own disable so it can fire
  a_reset_word: assert property (disable iff (1'b0)
    $fell(rst) |-> test_in == 32'h00000188)
    else $error("test word not default after reset");
  a_rsvd_one: assert property (test_in[1] == 1'b0)
    else $error("reserved bit 1 driven high");
  a_rsvd_pair: assert property (test_in[4:3] == 2'b01)
    else $error("reserved pair not 01");
  a_bit_eight: assert property (test_in[8] == 1'b1)
    else $error("bit 8 not held high");
  a_rsvd_high: assert property (test_in[31:9] == 23'h0)
    else $error("upper reserved bits not zero");
  a_ctrl_mirror: assert property (
    devkit_ctrl == (HAS_CONDUIT ? {224'h0, test_in} : 256'h0))
    else $error("board control does not mirror test word");
  // Word only moves when a write completes
  a_word_change: assert property (!$stable(test_in) |-> s_axi_bvalid)
    else $error("test word changed outside a write");
  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_resp_hold: assert property (s_b_waiting |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
endmodule // pctc_props

bind pctc_ctrl pctc_props #(.HAS_CONDUIT(HAS_CONDUIT)) i_props (
  .sys_clk(sys_clk), .rst(rst), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .test_in(test_in), .devkit_ctrl(devkit_ctrl)
);

/* pctc_defs.vh */
// Purpose: Shared constants for the test control conduit controller
// Assumes: Included by bare name from the controller, its checker and the bench
// Notes:   Offsets are byte addresses on the AXI4-Lite register window
`ifndef PCTC_DEFS_VH
`define PCTC_DEFS_VH

// ********************************************************************
// Register offsets of the controller window
// ********************************************************************
`define PCTC_ADDR_W         8
`define PCTC_REG_CTRL       8'h00
`define PCTC_REG_CMD        8'h04
`define PCTC_REG_STAT       8'h08
`define PCTC_REG_CRED       8'h0c
`define PCTC_REG_EVT        8'h10
`define PCTC_REG_UPTIME     8'h14
`define PCTC_REG_LIVE       8'h18

// ********************************************************************
// Test control word layout
// ********************************************************************
`define PCTC_TI_DEFAULT     32'h00000188
`define PCTC_TI_FREE_MASK   32'h000000e5
`define PCTC_TI_FIXED       32'h00000108
`define PCTC_TI_SIM_ACCEL   0
`define PCTC_TI_RSVD1       1
`define PCTC_TI_NO_SCRAMBLE 2
`define PCTC_TI_RSVD_LO     3
`define PCTC_TI_RSVD_HI     4
`define PCTC_TI_COMPL_HOLD  5
`define PCTC_TI_FORCE_COMPL 6
`define PCTC_TI_NO_LOWPWR   7
`define PCTC_TI_ALWAYS_ONE  8

// ********************************************************************
// Command register bits
// ********************************************************************
`define PCTC_CMD_APPLY      0
`define PCTC_CMD_TOGGLE     1

// ********************************************************************
// Board status bus fields
// ********************************************************************
`define PCTC_ST_USED_W      50
`define PCTC_ST_SPEED_LO    0
`define PCTC_ST_COR_RCV     2
`define PCTC_ST_COR_RPL     3
`define PCTC_ST_DATA_ERR    4
`define PCTC_ST_RX_PAR      5
`define PCTC_ST_TX_PAR_LO   6
`define PCTC_ST_TX_PAR_HI   7
`define PCTC_ST_CFG_PAR     8
`define PCTC_ST_LINK_UP     9
`define PCTC_ST_LINK_EXIT   10
`define PCTC_ST_TICK_128NS  11
`define PCTC_ST_TICK_1US    12
`define PCTC_ST_HOTRST_EXIT 13
`define PCTC_ST_INT_LO      14
`define PCTC_ST_SLEEP_EXIT  18
`define PCTC_ST_LANE_LO     19
`define PCTC_ST_LTSSM_LO    23
`define PCTC_ST_HDR_CR_LO   28
`define PCTC_ST_DAT_CR_LO   36
`define PCTC_ST_CPL_OVF     48
`define PCTC_ST_RESET_STAT  49

// ********************************************************************
// Event register bits
// ********************************************************************
`define PCTC_EVT_W          11
`define PCTC_EVT_REFUSED    10

// ********************************************************************
// AXI responses
// ********************************************************************
`define PCTC_RESP_OKAY      2'b00
`define PCTC_RESP_SLVERR    2'b10

`endif

/* pctc_sync2.v */
// Purpose: Two flip-flop synchroniser bank for status pins
// Assumes: Each bit is a slow level or a pulse wide enough to be seen
// Notes:   Bits are not sampled coherently; a multi-bit field may show
//          a mixed value for one cycle while it changes
`timescale 1ns/1ps

module pctc_sync2 #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             sys_clk,
  input  wire             rst,
  // Raw and synchronised levels
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;

  // One pair of flops per bit; the first stage feeds only the second
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg meta_reg;
      reg stable_reg;
      always @(posedge sys_clk)
      begin
        if (rst)
        begin
          meta_reg   <= 1'b0;
          stable_reg <= 1'b0;
        end
        else
        begin
          meta_reg   <= async_in[i];
          stable_reg <= meta_reg;
        end
      end
      assign sync_out[i] = stable_reg;
    end
  endgenerate

endmodule // pctc_sync2

/* tb.sv */
// Purpose: Register level test of the test control conduit controller
// Assumes: Simulation build so the descramble bit may be set
// Notes:   Status reads wait five cycles for the synchroniser
`timescale 1ns/1ps
`include "pctc_defs.vh"

module tb;
  reg          sys_clk, rst, awvalid, wvalid, bready, arvalid, rready;
  reg  [7:0]   awaddr, araddr;
  reg  [31:0]  wdata;
  reg          link_up, err_rcv;
  reg  [1:0]   width_sel, speed;
  reg  [7:0]   hdr_cr;
  reg  [11:0]  dat_cr;
  wire         awready, wready, bvalid, arready, rvalid, testin_zero;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata, test_in;
  wire [3:0]   lane_act;
  wire [255:0] devkit_ctrl, devkit_status;
  integer      n_mismatch, checks_done, cycles, i;

  pctc_ctrl #(.HAS_CONDUIT(1), .SIM_BUILD(1)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .test_in(test_in), .testin_zero(testin_zero), .lane_act(lane_act),
    .devkit_ctrl(devkit_ctrl), .devkit_status(devkit_status));

  pctc_core_model i_core (
    .sys_clk(sys_clk), .test_in(test_in), .testin_zero(testin_zero),
    .lane_act(lane_act), .link_up(link_up), .width_sel(width_sel), .speed(speed),
    .hdr_cr(hdr_cr), .dat_cr(dat_cr), .err_rcv(err_rcv), .devkit_status(devkit_status));

  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task end_sim;
    begin
      if (n_mismatch == 0 && checks_done > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task chk(input [255:0] seen, input [255:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // Write: handshakes judged at the falling edge, released after the rising one
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg ta, tw, da, dw;
    begin
      da = 1'b0;
      dw = 1'b0;
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(da && dw))
      begin
        @(negedge sys_clk);
        ta = awvalid & awready;
        tw = wvalid & wready;
        @(posedge sys_clk);
        if (ta) awvalid <= 1'b0;
        if (tw) wvalid <= 1'b0;
        da = da | ta;
        dw = dw | tw;
      end
      // Late ready makes the response wait a cycle
      repeat (2) @(posedge sys_clk);
      bready <= 1'b1;
      @(negedge sys_clk);
      while (bvalid !== 1'b1) @(negedge sys_clk);
      chk(bresp, er);
      @(posedge sys_clk);
      bready <= 1'b0;
    end
  endtask

  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    begin
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(negedge sys_clk);
      while (arready !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
      arvalid <= 1'b0;
      @(negedge sys_clk);
      while (rvalid !== 1'b1) @(negedge sys_clk);
      chk(rdata, ed);
      chk(rresp, er);
      @(posedge sys_clk);
      rready <= 1'b0;
    end
  endtask

  // Expected status word from link condition
  function [31:0] st_word(input l, input tz, input [3:0] ln, input [4:0] st, input [1:0] sp);
    st_word = {9'h0, 1'b0, ln, 1'b0, 4'h0, st, ln, tz, l, sp};
  endfunction

  // Hang guard; the run needs under two hundred cycles
  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      end_sim;
    end
  end

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, link_up, err_rcv} = 7'h0;
    {awaddr, araddr, wdata, width_sel, speed, hdr_cr, dat_cr} = 72'h0;
    {n_mismatch, checks_done, cycles} = 96'h0;
    rst = 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`PCTC_REG_CTRL, `PCTC_TI_DEFAULT, `PCTC_RESP_OKAY);
    rd(`PCTC_REG_LIVE, 32'h00000188, `PCTC_RESP_OKAY);
    chk(devkit_ctrl, {224'h0, 32'h00000188});
    rd(8'h1c, 32'h0, `PCTC_RESP_SLVERR);
    wr(8'h1c, 32'h0, `PCTC_RESP_SLVERR);
    wr(`PCTC_REG_STAT, 32'hffffffff, `PCTC_RESP_SLVERR);
    // All ones must leave the fixed bits alone
    wr(`PCTC_REG_CTRL, 32'hffffffff, `PCTC_RESP_OKAY);
    wr(`PCTC_REG_CMD, 32'h1, `PCTC_RESP_OKAY);
    chk(test_in, 32'h000001ed);
    chk(devkit_ctrl, {224'h0, 32'h000001ed});
    // Every lane code, training held off compliance by bit 5
    for (i = 0; i < 4; i = i + 1)
    begin
      width_sel <= i[1:0];
      repeat (5) @(posedge sys_clk);
      rd(`PCTC_REG_STAT, st_word(1'b0, 1'b1, 4'h1 << i, 5'h02, 2'h0),
         `PCTC_RESP_OKAY);
    end
    // Link up with credits and one error pulse
    link_up <= 1'b1;
    speed <= 2'h2;
    hdr_cr <= 8'h5a;
    dat_cr <= 12'ha5c;
    err_rcv <= 1'b1;
    repeat (5) @(posedge sys_clk);
    err_rcv <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rd(`PCTC_REG_STAT, st_word(1'b1, 1'b1, 4'h8, 5'h0f, 2'h2), `PCTC_RESP_OKAY);
    rd(`PCTC_REG_CRED, {12'h0, 12'ha5c, 8'h5a}, `PCTC_RESP_OKAY);
    rd(`PCTC_REG_UPTIME, 32'h1, `PCTC_RESP_OKAY);
    // Full reconfigure refused while up; compliance bit still copied
    wr(`PCTC_REG_CTRL, 32'h00000188, `PCTC_RESP_OKAY);
    wr(`PCTC_REG_CMD, 32'h1, `PCTC_RESP_OKAY);
    chk(test_in, 32'h000001cd);
    rd(`PCTC_REG_EVT, 32'h00000401, `PCTC_RESP_OKAY);
    wr(`PCTC_REG_CMD, 32'h2, `PCTC_RESP_OKAY);
    chk(test_in, 32'h000001ed);
    wr(`PCTC_REG_EVT, 32'h00000401, `PCTC_RESP_OKAY);
    rd(`PCTC_REG_EVT, 32'h0, `PCTC_RESP_OKAY);
    // Reset in mid-run returns the normal word
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(test_in, 32'h00000188);
    @(posedge sys_clk);
    rst <= 1'b0;
    rd(`PCTC_REG_CTRL, 32'h00000188, `PCTC_RESP_OKAY);
    end_sim;
  end
endmodule // tb
